// File: src/engine_out_cfg.svh
`ifndef ENGINE_OUT_CFG_SVH
`define ENGINE_OUT_CFG_SVH

// register byte offsets
`define OFS_ROLE        8'h00
`define OFS_THRESHOLD   8'h04
`define OFS_ALARM       8'h08
`define OFS_SPEED       8'h0C
`define OFS_STATUS      8'h10
// role field encodings
`define ROLE_ALARM      2'h0
`define ROLE_START      2'h1
// reset values
`define RST_ROLE        2'h0
`define RST_THRESHOLD   16'h0000
// status bit positions
`define ST_RELAY        0
`define ST_LATCHED      1
`define ST_PULSE        2
`define ST_SPEED_OK     3
// timing: clock rate and half-period math, speed in rev/min
`define CLK_HZ          32'h05F5E100
// clk * 60 / 2 as one constant, so no 32-bit product can overflow
`define HALF_CYCLES_PER_RPM 32'hB2D05E00
`define SPEED_TIMEOUT_MS 32'h000001F4
// 500 ms worth of clocks
`define SPEED_TIMEOUT_CYC 32'h02FAF080

`endif

// File: src/engine_out_pkg.sv
package engine_out_pkg;
  typedef struct packed {
    logic [15:0] speed;
    logic        valid;
    logic        alarmReq;
  } engine_in_t;

  typedef struct packed {
    logic [1:0]  role;
    logic [15:0] threshold;
    logic        swAlarm;
  } engine_cfg_t;

  typedef enum logic [1:0] {RS_ARMED, RS_ENGAGED, RS_RELEASED} relay_state_t;
endpackage

// File: src/speed_pulse_gen.sv
`default_nettype none
`include "engine_out_cfg.svh"
module speed_pulse_gen
  import engine_out_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] speed,
  output logic             pulse
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        level;
  } pg_state_t;

  pg_state_t st;
  pg_state_t next_st;
  logic [31:0] halfPeriod;

  // half period in clocks = clk*60 / (2*rpm)
  always_comb begin
    halfPeriod = (speed == 16'h0000) ? 32'h0000_0000 :
                 32'(`HALF_CYCLES_PER_RPM / {16'h0000, speed});
  end

  always_comb begin
    next_st = st;
    if (speed == 16'h0000) begin
      next_st.level = 1'b0;
      next_st.cnt   = 32'h0000_0000;
    end else if (st.cnt + 32'h0000_0001 >= halfPeriod) begin
      next_st.level = ~st.level;
      next_st.cnt   = 32'h0000_0000;
    end else begin
      next_st.cnt = st.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.level;

  AST_ZERO_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
    (speed == 16'h0000) |=> !pulse)
    else $error("pulse not low at zero speed");
endmodule
`default_nettype wire

// File: src/start_relay_ctl.sv
`default_nettype none
`include "engine_out_cfg.svh"
module start_relay_ctl
  import engine_out_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        enable,
  input  wire logic [15:0] speed,
  input  wire logic        speedValid,
  input  wire logic [15:0] threshold,
  output logic             relayOn,
  output logic             latched
);
  typedef struct packed {
    relay_state_t rs;
  } rc_state_t;

  rc_state_t st;
  rc_state_t next_st;

  always_comb begin
    next_st = st;
    unique case (st.rs)
      RS_ARMED:
        if (enable && speedValid && speed == 16'h0000) next_st.rs = RS_ENGAGED;
        else if (enable && speedValid && speed >= threshold) next_st.rs = RS_RELEASED;
      RS_ENGAGED:
        if (!enable) next_st.rs = RS_ARMED;
        else if (speedValid && speed >= threshold) next_st.rs = RS_RELEASED;
      RS_RELEASED:
        next_st.rs = RS_RELEASED;
      default: next_st.rs = RS_ARMED;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st.rs <= RS_ARMED;
    end else begin
      st <= next_st;
    end
  end

  assign relayOn = (st.rs == RS_ENGAGED);
  assign latched = (st.rs == RS_RELEASED);

  AST_NO_REENGAGE: assert property (@(posedge sys_clk) disable iff (!nrst)
    latched |=> latched && !relayOn)
    else $error("relay re-engaged after release");
  AST_RELEASE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (relayOn && enable && speedValid && speed >= threshold) |=> !relayOn)
    else $error("relay not released at threshold");
endmodule
`default_nettype wire

// File: src/engine_switch_and_rpm_pulse.sv
// Overview of operation
// - configuration picks relay or alarm role; switchPos follows only that role.
// - speed pulses come from the received engine speed value.
// - one pulse per revolution, fifty percent duty.
// - start power relay function is off after reset until role selects it.
// - start power mode keeps a configurable release speed threshold.
// - at power-up with zero speed, relay drive asserts and holds.
// - relay drive drops once speed reaches the threshold.
// - after release the relay stays off, even when the engine stops.
// - only a power cycle re-arms relay engagement.
// - high output energizes the relay coil, low releases it.
// - all delivered parameters used except auxiliary miscellaneous values.
// - alarm mode drives switchPos while the alarm request stands; switchNeg stays low.
// - alarm and start power roles are exclusive; exactly one active.
`default_nettype none
`include "engine_out_cfg.svh"
module engine_switch_and_rpm_pulse
  import engine_out_pkg::*;
#(
  parameter int unsigned SPEED_TIMEOUT = `SPEED_TIMEOUT_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // engine data from the decoder
  input  wire logic [15:0] rxSpeed,
  input  wire logic        rxSpeedStb,
  input  wire logic        rxAlarmReq,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  output logic             speed_pulse_pos,
  output logic             speed_pulse_neg,
  output logic             switchPos,
  output logic             switchNeg
);
  // ==========================================================
  // state
  typedef struct packed {
    engine_cfg_t cfg;
    logic [15:0] speed;
    logic        speedOk;
    logic [31:0] ageCnt;
    logic        awHave;
    logic [7:0]  awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [1:0]  bResp;
    logic        pulseQ;
    logic        swQ;
    logic        awRdy;
    logic        wRdy;
    logic        arRdy;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic        pulseRaw;
  logic        relayOn;
  logic        latched;
  logic        startMode;
  logic [31:0] wr;

  assign startMode = (st.cfg.role == `ROLE_START);

  // ==========================================================
  // sub-blocks
  speed_pulse_gen u_pulse (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .speed   (st.speedOk ? st.speed : 16'h0000),
    .pulse   (pulseRaw)
  );

  start_relay_ctl u_relay (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .enable     (startMode),
    .speed      (st.speed),
    .speedValid (st.speedOk),
    .threshold  (st.cfg.threshold),
    .relayOn    (relayOn),
    .latched    (latched)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    wr      = 32'h0000_0000;

    // speed capture and staleness watch
    if (rxSpeedStb) begin
      next_st.speed   = rxSpeed;
      next_st.speedOk = 1'b1;
      next_st.ageCnt  = 32'h0000_0000;
    end else if (st.ageCnt >= SPEED_TIMEOUT - 1) begin
      next_st.speedOk = 1'b0;
    end else begin
      next_st.ageCnt = st.ageCnt + 32'h0000_0001;
    end

    // write channel capture
    if (s_axi_awvalid && st.awRdy) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wRdy) begin
      next_st.wHave = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.awHave && st.wHave) begin
      next_st.awHave = 1'b0;
      next_st.wHave  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = 2'h0;
      for (int i = 0; i < 4; i++) begin
        wr[i*8 +: 8] = st.wStrb[i] ? st.wData[i*8 +: 8] : 8'h00;
      end
      unique case (st.awAddr & 8'hFC)
        `OFS_ROLE:      if (st.wStrb[0]) next_st.cfg.role = wr[1:0];
        `OFS_THRESHOLD: begin
          if (st.wStrb[0]) next_st.cfg.threshold[7:0]  = wr[7:0];
          if (st.wStrb[1]) next_st.cfg.threshold[15:8] = wr[15:8];
        end
        `OFS_ALARM:     if (st.wStrb[0]) next_st.cfg.swAlarm = wr[0];
        `OFS_SPEED, `OFS_STATUS: next_st.bResp = 2'h0;
        default:        next_st.bResp = 2'h2;
      endcase
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end

    // read channel
    if (s_axi_arvalid && st.arRdy) begin
      next_st.rValid = 1'b1;
      next_st.rResp  = 2'h0;
      unique case (s_axi_araddr & 8'hFC)
        `OFS_ROLE:      next_st.rData = {30'h0, st.cfg.role};
        `OFS_THRESHOLD: next_st.rData = {16'h0000, st.cfg.threshold};
        `OFS_ALARM:     next_st.rData = {31'h0, st.cfg.swAlarm};
        `OFS_SPEED:     next_st.rData = {16'h0000, st.speed};
        `OFS_STATUS:    next_st.rData = {28'h0, st.speedOk, st.pulseQ, latched, relayOn};
        default: begin
          next_st.rData = 32'h0000_0000;
          next_st.rResp = 2'h2;
        end
      endcase
    end else if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end

    // pin drive, registered
    next_st.pulseQ = pulseRaw;
    if (startMode) begin
      next_st.swQ = relayOn;
    end else begin
      next_st.swQ = rxAlarmReq | st.cfg.swAlarm;
    end

    // bus ready flags come from flops, computed one cycle ahead
    next_st.awRdy = !next_st.awHave && !next_st.bValid;
    next_st.wRdy  = !next_st.wHave && !next_st.bValid;
    next_st.arRdy = !next_st.rValid;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st          <= '0;
      st.cfg.role <= `RST_ROLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready   = st.awRdy;
  assign s_axi_wready    = st.wRdy;
  assign s_axi_bvalid    = st.bValid;
  assign s_axi_bresp     = st.bResp;
  assign s_axi_arready   = st.arRdy;
  assign s_axi_rvalid    = st.rValid;
  assign s_axi_rdata     = st.rData;
  assign s_axi_rresp     = st.rResp;
  assign speed_pulse_pos = st.pulseQ;
  assign speed_pulse_neg = 1'b0;
  assign switchPos       = st.swQ;
  assign switchNeg       = 1'b0;

  // ==========================================================
  // checks
  AST_ALARM_ROLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!startMode && $stable(st.cfg.role) && rxAlarmReq) |=> switchPos)
    else $error("alarm request not driven");
  AST_ROLE_EXCL: assert property (@(posedge sys_clk) disable iff (!nrst)
    (startMode && $stable(st.cfg.role) && !relayOn) |=> !switchPos)
    else $error("switch driven without relay in start mode");
  AST_RELAY_PIN: assert property (@(posedge sys_clk) disable iff (!nrst)
    (startMode && relayOn) |=> switchPos)
    else $error("relay pin not high while engaged");
  AST_RESET_OFF: assert property (@(posedge sys_clk)
    $rose(nrst) |-> !startMode && !relayOn)
    else $error("start role active after reset");
  AST_PULSE_SRC: assert property (@(posedge sys_clk) disable iff (!nrst)
    !st.speedOk [*3] |-> !speed_pulse_pos)
    else $error("pulse without received speed");

  // ==========================================================
  // bus checks
  AST_AW_BUSY: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write channel open while response pending");

  AST_AR_BUSY: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_axi_rvalid |->
    !s_axi_arready)
    else $error("read channel open while data pending");

  AST_B_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_axi_bvalid && !s_axi_bready) |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  AST_R_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_axi_rvalid && !s_axi_rready) |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before taken");

  AST_B_DONE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_axi_bvalid && s_axi_bready) |=>
    !s_axi_bvalid)
    else $error("write response repeated");

  AST_R_DONE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_axi_rvalid && s_axi_rready) |=>
    !s_axi_rvalid)
    else $error("read data repeated");

  AST_R_ANSWER: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_axi_arvalid && s_axi_arready) |=>
    s_axi_rvalid)
    else $error("read not answered");

  AST_B_ANSWER: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st.awHave && st.wHave) |=>
    s_axi_bvalid)
    else $error("write not answered");

  AST_BAD_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st.awHave && st.wHave && (st.awAddr & 8'hFC) > `OFS_STATUS) |=>
    s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");

  AST_ROLE_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st.awHave && st.wHave && (st.awAddr & 8'hFC) == `OFS_ROLE && st.wStrb[0]) |=>
    st.cfg.role == $past(st.wData[1:0]))
    else $error("role write lost");

  AST_THRESH_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st.awHave && st.wHave && (st.awAddr & 8'hFC) == `OFS_THRESHOLD && st.wStrb[1:0] == 2'h3) |=>
    st.cfg.threshold == $past(st.wData[15:0]))
    else $error("threshold write lost");

  // ==========================================================
  // rule checks
  AST_SPEED_TAKE: assert property (@(posedge sys_clk) disable iff (!nrst)
    rxSpeedStb |=>
    st.speed == $past(rxSpeed) && st.speedOk)
    else $error("received speed not taken");

  AST_RO_SPEED: assert property (@(posedge sys_clk) disable iff (!nrst)
    !rxSpeedStb |=>
    $stable(st.speed))
    else $error("speed changed without a received value");

  AST_STALE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!rxSpeedStb && st.ageCnt >= SPEED_TIMEOUT - 1) |=>
    !st.speedOk)
    else $error("stale speed still marked fresh");

  AST_PULSE_PIN: assert property (@(posedge sys_clk) disable iff (!nrst)
    1'b1 |=>
    speed_pulse_pos == $past(pulseRaw))
    else $error("pulse pin does not follow generator");

  AST_ZERO_PIN: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st.speedOk && st.speed == 16'h0000) [*3] |->
    !speed_pulse_pos)
    else $error("pulse pin active at zero speed");

  AST_RELAY_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    !startMode |=>
    !relayOn)
    else $error("relay engaged outside start power role");

  AST_ENGAGE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (startMode && !relayOn && !latched && st.speedOk && st.speed == 16'h0000) |=>
    relayOn)
    else $error("relay not engaged at zero speed");

  AST_HOLD_ON: assert property (@(posedge sys_clk) disable iff (!nrst)
    (relayOn && startMode && !(st.speedOk && st.speed >= st.cfg.threshold)) |=>
    relayOn)
    else $error("relay dropped below threshold");

  AST_LATCH_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
    (relayOn && startMode && st.speedOk && st.speed >= st.cfg.threshold) |=>
    latched)
    else $error("release not latched at threshold");

  AST_STAY_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
    (latched && !startMode) |=>
    latched && !relayOn)
    else $error("role change re-armed relay");

  AST_SW_START: assert property (@(posedge sys_clk) disable iff (!nrst)
    startMode |=>
    switchPos == $past(relayOn))
    else $error("switch pin does not follow relay");

  AST_ALARM_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!startMode && !rxAlarmReq && !st.cfg.swAlarm) |=>
    !switchPos)
    else $error("alarm pin active without request");
endmodule
`default_nettype wire

// File: verif/ecu_speed_src.sv
`default_nettype none
module ecu_speed_src (
  input  wire logic        sys_clk,
  input  wire logic        srcOn,
  input  wire logic [15:0] cmdSpeed,
  output logic [15:0]      rxSpeed,
  output logic             rxSpeedStb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] tick;
  initial begin
    tick = 3'h0;
    rxSpeed = 16'h0;
    rxSpeedStb = 1'b0;
  end
  // frames only while switched on; otherwise the value line carries garbage
  always @(posedge sys_clk) begin
    tick <= tick + 3'h1;
    rxSpeedStb <= srcOn && tick == 3'h0;
    rxSpeed <= srcOn ? cmdSpeed : ~rxSpeed;
  end
endmodule
`default_nettype wire

// File: verif/test_engine_switch_and_rpm_pulse.sv
`default_nettype none
`include "engine_out_cfg.svh"
module test_engine_switch_and_rpm_pulse;
  timeunit 1ns;
  timeprecision 1ns;
  // cycles of one high phase at top speed
  localparam longint HALF = `HALF_CYCLES_PER_RPM / 32'h0000FFFF;
  logic        sys_clk = 1'b0, nrst = 1'b0, rxAlarmReq = 1'b0, srcOn = 1'b0;
  logic [15:0] cmdSpeed = 16'h0, rxSpeed;
  logic        rxSpeedStb, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rdat;
  logic [1:0]  bresp, rresp, resp;
  logic        pulsePos, pulseNeg, switchPos, switchNeg;
  int          err_count = 0, compares = 0, n;

  always #5 sys_clk = ~sys_clk;

  ecu_speed_src src_u (.sys_clk(sys_clk), .srcOn(srcOn), .cmdSpeed(cmdSpeed),
    .rxSpeed(rxSpeed), .rxSpeedStb(rxSpeedStb));

  engine_switch_and_rpm_pulse #(.SPEED_TIMEOUT(100)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .rxSpeed(rxSpeed), .rxSpeedStb(rxSpeedStb),
    .rxAlarmReq(rxAlarmReq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .speed_pulse_pos(pulsePos), .speed_pulse_neg(pulseNeg),
    .switchPos(switchPos), .switchNeg(switchNeg));

  // ====
  // bus and compare tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // wait for the switch level, or watch it hold for the whole span
  task automatic sw(input logic exp, input logic hold);
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if ((switchPos === exp) != hold) break;
    end
    check({31'h0, switchPos}, {31'h0, exp});
  endtask

  task automatic tally_and_finish();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ====
  // sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`OFS_ROLE);
    check(rdat, 32'h0);
    rd(`OFS_THRESHOLD);
    check(rdat, 32'h0);
    check({31'h0, pulsePos}, 32'h0);
    rd(8'h20);
    check({30'h0, resp}, 32'h2);
    wr(8'h20, 32'h1);
    check({30'h0, resp}, 32'h2);
    rxAlarmReq <= 1'b1;
    sw(1'b1, 1'b0);
    rxAlarmReq <= 1'b0;
    sw(1'b0, 1'b0);
    wr(`OFS_ALARM, 32'h1);
    sw(1'b1, 1'b0);
    wr(`OFS_ALARM, 32'h0);
    wr(`OFS_THRESHOLD, 32'h3E8);
    wr(`OFS_ROLE, 32'h1);
    rxAlarmReq <= 1'b1;
    sw(1'b0, 1'b1);
    srcOn <= 1'b1;
    sw(1'b1, 1'b0);
    rd(`OFS_STATUS);
    check(rdat & 32'h3, 32'h1);
    cmdSpeed <= 16'h3E7;
    sw(1'b1, 1'b1);
    cmdSpeed <= 16'h3E8;
    sw(1'b0, 1'b0);
    cmdSpeed <= 16'h0;
    sw(1'b0, 1'b1);
    srcOn <= 1'b0;
    wr(`OFS_ROLE, 32'h0);
    rxAlarmReq <= 1'b0;
    wr(`OFS_ROLE, 32'h1);
    srcOn <= 1'b1;
    sw(1'b0, 1'b1);
    rd(`OFS_STATUS);
    check(rdat & 32'h3, 32'h2);
    wr(`OFS_SPEED, 32'h1234);
    check({30'h0, resp}, 32'h0);
    rd(`OFS_SPEED);
    check(rdat, 32'h0);
    nrst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`OFS_ROLE);
    check(rdat, 32'h0);
    wr(`OFS_THRESHOLD, 32'h3E8);
    wr(`OFS_ROLE, 32'h1);
    sw(1'b1, 1'b0);
    cmdSpeed <= 16'hFFFF;
    n = 0;
    while (pulsePos !== 1'b1 && n < 60000) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pulsePos === 1'b1 && n < 60000);
    check(32'(n >= HALF - 2 && n <= HALF + 2), 32'h1);
    check({31'h0, pulseNeg}, 32'h0);
    check({31'h0, switchNeg}, 32'h0);
    rd(`OFS_SPEED);
    check(rdat, 32'hFFFF);
    check({30'h0, resp}, 32'h0);
    tally_and_finish();
  end

  initial begin
    #970000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
